/* hw/flag_bank_pkg.sv */
// Purpose: shared constants and carrier types for the bus transceiver status flag bank
// Assumes: 32-bit apb data, one aligned word per register, 40 MHz pclk
// Notes: latched flags clear on a read of the flag register once their cause is gone

package flag_bank_pkg;

   // register byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] LIVE_OFFSET = 8'h04;
   localparam logic [7:0] FLAGS_OFFSET = 8'h08;
   localparam logic [7:0] PEEK_OFFSET = 8'h0C;
   localparam logic [7:0] CAUSE_OFFSET = 8'h10;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h14;
   localparam logic [7:0] IRQ_MASK_OFFSET = 8'h18;

   // serial status read command code of the original frame format
   localparam logic [15:0] STATUS_READ_CMD = 16'h2180;

   // control field positions and reset values
   localparam int CTRL_RX_ONLY_BIT = 0;
   localparam int CTRL_SLEEP_BIT = 1;
   localparam int CTRL_WAKE_RX_BIT = 2;
   localparam logic CTRL_RX_ONLY_RESET = 1'b0;
   localparam logic CTRL_SLEEP_RESET = 1'b0;
   localparam logic CTRL_WAKE_RX_RESET = 1'b1;

   // timing
   localparam int CLK_PERIOD_NS = 32'h0000_0019;
   localparam int DOMINANT_TIMEOUT_NS = 32'h000F_4240;
   localparam int DOMINANT_TIMEOUT_CYCLES = (DOMINANT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int FLAG_W = 10;

   typedef struct packed {
      logic rx_only;
      logic sleep;
      logic wake_rx_en;
   } ctrl_t;

   typedef struct packed {
      logic wake_rx;
      logic receiver;
      logic driver;
   } live_t;

   // bit 0 is wake, bit 9 is parity error
   typedef struct packed {
      logic parity_err;
      logic fault_confirmed;
      logic fault_suspected;
      logic overcurrent;
      logic dom_clamp;
      logic txd_dom;
      logic rxd_high;
      logic rxd_low;
      logic overtemp;
      logic wake;
   } flags_t;

endpackage

/* hw/flag_latch.sv */
// Purpose: latched fault flags with read-to-clear gated by the cause
// Assumes: set and hold are levels or pulses sampled on pclk
// Notes: a set in the clearing cycle wins over the clear

`timescale 1ns/10ps
`default_nettype none

module flag_latch #(
   parameter int WIDTH = 10
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // flag control
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] hold,
   input wire logic [WIDTH-1:0] clear,
   // flag state
   output logic [WIDTH-1:0] flags,
   output logic [WIDTH-1:0] rise
);

   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } latch_state_t;

   latch_state_t state, next_state;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("flag_latch needs at least one flag");
      end
   endgenerate

   always_comb begin
      next_state = state;
      // clear only where the cause has gone; set wins over clear
      next_state.flags = (state.flags & ~(clear & ~hold)) | set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign flags = state.flags;
   assign rise = set & ~state.flags;

endmodule

`default_nettype wire

/* hw/dominant_timer.sv */
// Purpose: detect a bus held dominant for longer than the dominant timeout
// Assumes: bus_dominant is a synchronous level
// Notes: timed_out stays high until the bus goes recessive

`timescale 1ns/10ps
`default_nettype none

module dominant_timer #(
   parameter int LIMIT = 40000
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bus level
   input wire logic bus_dominant,
   // result
   output logic timed_out
);

   localparam int CW = $clog2(LIMIT + 1);

   typedef struct packed {
      logic [CW-1:0] count;
      logic timed_out;
   } timer_state_t;

   timer_state_t state, next_state;

   generate
      if (LIMIT < 1) begin : g_bad_limit
         $error("dominant_timer limit must be at least one cycle");
      end
   endgenerate

   always_comb begin
      next_state = state;
      if (!bus_dominant) begin
         next_state.count = '0;
         next_state.timed_out = 1'b0;
      end else if (state.count >= CW'(LIMIT)) begin
         // saturate so a very long clamp never wraps back to clear
         next_state.timed_out = 1'b1;
      end else begin
         next_state.count = state.count + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign timed_out = state.timed_out;

endmodule

`default_nettype wire

/* hw/can_status_flag_bank.sv */
// Purpose: apb register bank holding live transceiver state and latched fault flags
// Assumes: fault sensor inputs are synchronous to pclk; pulses last one cycle
// Notes: one wait state on every apb access; flag register reads clear eligible flags

`timescale 1ns/10ps
`default_nettype none

module can_status_flag_bank
   import flag_bank_pkg::*;
#(
   parameter int DOM_TIMEOUT_CYCLES = DOMINANT_TIMEOUT_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // fault and event sources
   input wire logic bus_wake_detect,
   input wire logic thermal_over,
   input wire logic rxd_low_fault,
   input wire logic rxd_high_fault,
   input wire logic txd_dom_fault,
   input wire logic bus_dominant,
   input wire logic current_over,
   input wire logic fault_predetect,
   input wire logic fault_detected,
   input wire logic parity_error,
   // transceiver control
   output logic driver_enable,
   output logic receiver_enable,
   output logic bus_wake_receiver,
   // interrupt
   output logic irq
);

   typedef struct packed {
      ctrl_t ctrl;
      live_t live;
      flags_t irq_status;
      flags_t irq_mask;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } bank_state_t;

   bank_state_t state, next_state;

   logic dom_timed_out;
   flags_t flag_set, flag_hold, flag_clear, flags, flag_rise;
   logic access_done;
   logic wr_done;
   logic rd_done;

   generate
      if (DOM_TIMEOUT_CYCLES < 1) begin : g_bad_timeout
         $error("dominant timeout must be at least one cycle");
      end
   endgenerate

   // true when the offset names a register of this bank
   function automatic logic is_mapped(input logic [7:0] addr);
      case (addr)
         CTRL_OFFSET, LIVE_OFFSET, FLAGS_OFFSET, PEEK_OFFSET,
         CAUSE_OFFSET, IRQ_STATUS_OFFSET, IRQ_MASK_OFFSET: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // merge write data into a register under the byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = wdata[8*i +: 8];
         end
      end
      merge = res;
   endfunction

   dominant_timer #(
      .LIMIT(DOM_TIMEOUT_CYCLES)
   ) u_dom_timer (
      .pclk(pclk),
      .presetn(presetn),
      .bus_dominant(bus_dominant),
      .timed_out(dom_timed_out)
   );

   // level causes both set and hold their flag; pulse events only set
   always_comb begin
      flag_set = '0;
      flag_hold = '0;
      flag_set.wake = bus_wake_detect;
      flag_set.overtemp = thermal_over;
      flag_hold.overtemp = thermal_over;
      flag_set.rxd_low = rxd_low_fault;
      flag_hold.rxd_low = rxd_low_fault;
      flag_set.rxd_high = rxd_high_fault;
      flag_hold.rxd_high = rxd_high_fault;
      flag_set.txd_dom = txd_dom_fault;
      flag_hold.txd_dom = txd_dom_fault;
      flag_set.dom_clamp = dom_timed_out;
      flag_hold.dom_clamp = dom_timed_out;
      flag_set.overcurrent = current_over;
      flag_hold.overcurrent = current_over;
      flag_set.fault_suspected = fault_predetect;
      flag_hold.fault_suspected = fault_predetect | fault_detected;
      flag_set.fault_confirmed = fault_detected;
      flag_hold.fault_confirmed = fault_predetect | fault_detected;
      flag_set.parity_err = parity_error;
   end

   assign access_done = psel & penable & state.pready;
   assign wr_done = access_done & pwrite;
   assign rd_done = access_done & ~pwrite;

   // only the bits the finishing read returned are offered for clearing
   always_comb begin
      flag_clear = '0;
      if (rd_done && paddr == FLAGS_OFFSET) begin
         flag_clear = flags_t'(state.prdata[FLAG_W-1:0]);
      end
   end

   flag_latch #(
      .WIDTH(FLAG_W)
   ) u_flags (
      .pclk(pclk),
      .presetn(presetn),
      .set(flag_set),
      .hold(flag_hold),
      .clear(flag_clear),
      .flags(flags),
      .rise(flag_rise)
   );

   always_comb begin
      logic [31:0] wword;
      flags_t cause;
      wword = '0;
      cause = flag_set | flag_hold;
      next_state = state;

      // apb: one wait state, then the access completes
      next_state.pready = 1'b0;
      next_state.pslverr = 1'b0;
      if (psel && penable && !state.pready) begin
         next_state.pready = 1'b1;
         next_state.pslverr = ~is_mapped(paddr);
         next_state.prdata = '0;
         if (!pwrite) begin
            case (paddr)
               CTRL_OFFSET: begin
                  next_state.prdata[CTRL_RX_ONLY_BIT] = state.ctrl.rx_only;
                  next_state.prdata[CTRL_SLEEP_BIT] = state.ctrl.sleep;
                  next_state.prdata[CTRL_WAKE_RX_BIT] = state.ctrl.wake_rx_en;
               end
               LIVE_OFFSET: next_state.prdata[2:0] = state.live;
               FLAGS_OFFSET: next_state.prdata[FLAG_W-1:0] = flags;
               PEEK_OFFSET: next_state.prdata[FLAG_W-1:0] = flags;
               CAUSE_OFFSET: next_state.prdata[FLAG_W-1:0] = cause;
               IRQ_STATUS_OFFSET: next_state.prdata[FLAG_W-1:0] = state.irq_status;
               IRQ_MASK_OFFSET: next_state.prdata[FLAG_W-1:0] = state.irq_mask;
               default: next_state.prdata = '0;
            endcase
         end
      end

      // writes take effect at the completing edge only
      if (wr_done) begin
         case (paddr)
            CTRL_OFFSET: begin
               wword = merge({29'h0000_0000, state.ctrl.wake_rx_en, state.ctrl.sleep,
                              state.ctrl.rx_only}, pwdata, pstrb);
               next_state.ctrl.rx_only = wword[CTRL_RX_ONLY_BIT];
               next_state.ctrl.sleep = wword[CTRL_SLEEP_BIT];
               next_state.ctrl.wake_rx_en = wword[CTRL_WAKE_RX_BIT];
            end
            IRQ_STATUS_OFFSET: begin
               wword = merge(32'h0000_0000, pwdata, pstrb);
               next_state.irq_status = state.irq_status & ~flags_t'(wword[FLAG_W-1:0]);
            end
            IRQ_MASK_OFFSET: begin
               wword = merge({22'h00_0000, state.irq_mask}, pwdata, pstrb);
               next_state.irq_mask = flags_t'(wword[FLAG_W-1:0]);
            end
            default: wword = '0;
         endcase
      end

      // a new flag rising in the clearing cycle still sets its status bit
      next_state.irq_status = next_state.irq_status | flag_rise;
      next_state.irq = |(next_state.irq_status & next_state.irq_mask);

      // live state follows control and faults, never reads
      next_state.live.driver = ~state.ctrl.sleep & ~state.ctrl.rx_only
                               & ~txd_dom_fault & ~dom_timed_out;
      next_state.live.receiver = ~state.ctrl.sleep;
      next_state.live.wake_rx = state.ctrl.wake_rx_en;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
         state.ctrl.rx_only <= CTRL_RX_ONLY_RESET;
         state.ctrl.sleep <= CTRL_SLEEP_RESET;
         state.ctrl.wake_rx_en <= CTRL_WAKE_RX_RESET;
         state.live.wake_rx <= CTRL_WAKE_RX_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign prdata = state.prdata;
   assign pready = state.pready;
   assign pslverr = state.pslverr;
   assign driver_enable = state.live.driver;
   assign receiver_enable = state.live.receiver;
   assign bus_wake_receiver = state.live.wake_rx;
   assign irq = state.irq;

endmodule

`default_nettype wire

/* bench/flag_bank_monitor.sv */
// Purpose: port checker for the transceiver status flag bank
// Assumes: one wait state on every apb access, live bits lag control by one edge
// Notes: bound to every instance of the bank
`timescale 1ns/10ps
`default_nettype none
module flag_bank_monitor
   import flag_bank_pkg::*;
#(
   parameter int DOM_TIMEOUT_CYCLES = DOMINANT_TIMEOUT_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // fault and event sources
   input wire logic thermal_over,
   input wire logic rxd_low_fault,
   input wire logic txd_dom_fault,
   input wire logic current_over,
   // transceiver control and interrupt
   input wire logic driver_enable,
   input wire logic receiver_enable,
   input wire logic bus_wake_receiver,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic done;
   logic wr_ctrl;
   logic rd_flags;
   assign done = psel && penable && pready;
   assign wr_ctrl = done && pwrite && paddr == CTRL_OFFSET && pstrb[0];
   assign rd_flags = done && !pwrite && paddr == FLAGS_OFFSET;
   a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("apb answer not after exactly one wait state");
   a_err_unmapped: assert property (done && paddr > IRQ_MASK_OFFSET |-> pslverr && (pwrite || prdata == 0))
      else $error("unmapped access not refused");
   a_wake_rx_follow: assert property (wr_ctrl |-> ##2 bus_wake_receiver == $past(pwdata[2], 2))
      else $error("wake receiver state not following control");
   a_rx_sleep_off: assert property (wr_ctrl |-> ##2 receiver_enable == !$past(pwdata[1], 2))
      else $error("receiver state not following sleep setting");
   a_rx_only_off: assert property (wr_ctrl && pwdata[0] |-> ##2 !driver_enable)
      else $error("driver still enabled in receive only setting");
   a_drv_fault_off: assert property (txd_dom_fault [*2] |-> !driver_enable)
      else $error("driver enabled during transmit pin fault");
   a_live_read_stable: assert property (psel && penable && !pwrite |=> $stable(bus_wake_receiver))
      else $error("read changed live wake receiver state");
   a_hot_flag_read: assert property (rd_flags && $past(thermal_over, 3) |-> prdata[1])
      else $error("overtemperature flag missing while hot");
   a_cur_flag_read: assert property (rd_flags && $past(current_over, 3) |-> prdata[6])
      else $error("overcurrent flag missing while over limit");
   a_rxd_flag_read: assert property (rd_flags && $past(rxd_low_fault, 3) |-> prdata[2])
      else $error("receive pin low flag missing during fault");
   a_mask_zero_irq: assert property (done && pwrite && paddr == IRQ_MASK_OFFSET && pwdata == 0
      && pstrb == 4'hF |-> ##2 !irq)
      else $error("interrupt high with all sources masked");
endmodule
bind can_status_flag_bank flag_bank_monitor #(.DOM_TIMEOUT_CYCLES(DOM_TIMEOUT_CYCLES)) mon (.*);
`default_nettype wire

/* bench/mcu_apb_model.sv */
// Purpose: microcontroller side apb master that reads and writes the bank
// Assumes: called just after a rising edge or at time zero
// Notes: one idle cycle between transfers keeps each signal to one update per step
`timescale 1ns/10ps
`default_nettype none
module mcu_apb_model (
   // clock
   input wire logic pclk,
   // apb master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // byte strobes of the next transfer; the bench narrows them to exercise merging
   logic [3:0] strb_cfg = 4'hF;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
   end
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err, output logic to);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= strb_cfg;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      q = prdata;
      err = pslverr;
      to = (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // released data is scrambled so a stale value never looks valid
      pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: self-checking bench for the transceiver status flag bank
// Assumes: dominant timeout shortened to 8 cycles
// Notes: random cause patterns are held long enough for every flag to set
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import flag_bank_pkg::*;
();
   localparam int DOM = 8;
   logic pclk = 1'b0;
   logic presetn;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, r;
   logic [3:0] pstrb;
   logic bus_wake_detect, thermal_over, rxd_low_fault, rxd_high_fault, txd_dom_fault;
   logic bus_dominant, current_over, fault_predetect, fault_detected, parity_error;
   logic driver_enable, receiver_enable, bus_wake_receiver, irq, e;
   logic [9:0] c, fl;
   logic [31:0] seed = 32'h0000_3EBB;
   int n_mismatch = 0;
   int total_checks = 0;
   always #12.5 pclk = ~pclk;
   can_status_flag_bank #(.DOM_TIMEOUT_CYCLES(DOM)) dut (.*);
   mcu_apb_model mcu (.*);
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // pulse sources never hold a flag; both bus fault flags share one cause
   function automatic logic [9:0] cause(input logic [9:0] s);
      cause = s & 10'h07E;
      if (s[7] || s[8]) cause = cause | 10'h180;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic to;
      mcu.xfer(wr, a, d, q, e, to);
      if (to) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   task automatic drive(input logic [9:0] s);
      @(posedge pclk);
      {fault_detected, fault_predetect, current_over, bus_dominant, txd_dom_fault} <= s[8:4];
      {rxd_high_fault, rxd_low_fault, thermal_over} <= s[3:1];
      bus_wake_detect <= s[0];
      parity_error <= s[9];
      @(posedge pclk);
      bus_wake_detect <= 1'b0;
      parity_error <= 1'b0;
      repeat (DOM + 4) @(posedge pclk);
   endtask
   initial begin
      presetn = 1'b0;
      {bus_wake_detect, thermal_over, rxd_low_fault, rxd_high_fault, txd_dom_fault} = 5'h0;
      {bus_dominant, current_over, fault_predetect, fault_detected, parity_error} = 5'h0;
      fl = 10'h000;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      acc(1'b0, CTRL_OFFSET, 32'h0000_0000);
      check("ctrl", 32'h0000_0004, q);
      acc(1'b0, LIVE_OFFSET, 32'h0000_0000);
      check("live", 32'h0000_0007, q);
      for (int i = 0; i < 8; i++) begin
         acc(1'b1, CTRL_OFFSET, i);
         acc(1'b0, LIVE_OFFSET, 32'h0000_0000);
         r = {29'h0, i[2], !i[1], !(i[0] || i[1])};
         check("live", r, q);
         check("pins", r, {29'h0, bus_wake_receiver, receiver_enable, driver_enable});
      end
      // byte 0 not strobed: the control bits must keep their value
      mcu.strb_cfg = 4'hE;
      acc(1'b1, CTRL_OFFSET, 32'h0000_0000);
      mcu.strb_cfg = 4'hF;
      acc(1'b0, CTRL_OFFSET, 32'h0000_0000);
      check("ctrl strobe", 32'h0000_0007, q);
      acc(1'b1, CTRL_OFFSET, 32'h0000_0004);
      acc(1'b1, IRQ_MASK_OFFSET, 32'h0000_03FF);
      for (int k = 0; k < 25; k++) begin
         r = xs();
         c = (k == 24) ? 10'h000 : r[9:0];
         drive(c);
         fl = fl | c;
         acc(1'b0, PEEK_OFFSET, 32'h0000_0000);
         check("peek", {22'h0, fl}, q);
         acc(1'b0, CAUSE_OFFSET, 32'h0000_0000);
         check("cause", {22'h0, cause(c)}, q);
         acc(1'b0, FLAGS_OFFSET, 32'h0000_0000);
         check("flags", {22'h0, fl}, q);
         fl = fl & cause(c);
         acc(1'b0, LIVE_OFFSET, 32'h0000_0000);
         check("live", {29'h0, 2'b11, !(c[4] || c[5])}, q);
      end
      acc(1'b0, FLAGS_OFFSET, 32'h0000_0000);
      check("flags", 32'h0000_0000, q);
      acc(1'b1, IRQ_STATUS_OFFSET, 32'h0000_03FF);
      repeat (2) @(posedge pclk);
      check("irq", 32'h0000_0000, {31'h0, irq});
      drive(10'h002);
      check("irq", 32'h0000_0001, {31'h0, irq});
      acc(1'b0, IRQ_STATUS_OFFSET, 32'h0000_0000);
      check("status", 32'h0000_0002, q);
      acc(1'b1, IRQ_MASK_OFFSET, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      check("irq", 32'h0000_0000, {31'h0, irq});
      acc(1'b1, IRQ_MASK_OFFSET, 32'h0000_03FF);
      repeat (2) @(posedge pclk);
      check("irq", 32'h0000_0001, {31'h0, irq});
      acc(1'b1, IRQ_STATUS_OFFSET, 32'h0000_0002);
      repeat (2) @(posedge pclk);
      check("irq", 32'h0000_0000, {31'h0, irq});
      acc(1'b0, 8'h40, 32'h0000_0000);
      check("unmapped", 32'h0000_0001, {31'h0, e});
      check("unmapped data", 32'h0000_0000, q);
      complete_run();
   end
endmodule
`default_nettype wire
